/* logic/mpi_mac_pins.sv */
`timescale 1ns/1ns
`include "mpi_consts.svh"

// Overview of operation
// - valid rises with first preamble nibble, stays
// - valid drops before edge after last nibble
// - data meaningful only while valid; serial bit0
// - transmit pins timed to PHY transmit clock
// - error held with valid forces illegal symbols
// - error ignored when idle or serial mode
// - capture receive data only while valid
// - receive error ignored while valid low
// - controller drives management clock, data follows
// - management data undriven after reset
// - select input routes shared pins to ethernet
module mpi_mac_pins
#(
  parameter int FIFO_DEPTH   = `MPI_FIFO_DEPTH,
  parameter int MDC_HALF_CYC = `MPI_MDC_HALF_CYC
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        serial_mode_i,
  input  wire logic        pin_function_select_i,
  input  wire logic [7:0]  tx_byte_i,
  input  wire logic        tx_last_i,
  input  wire logic        tx_err_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  output logic             tx_underrun_o,
  input  wire logic        tx_nibble_clock_i,
  output logic             tx_frame_valid_o,
  output logic             tx_serial_bit0_o,
  output logic [2:0]       tx_nibble_upper_o,
  output logic             tx_symbol_error_o,
  input  wire logic        rx_nibble_clock_i,
  input  wire logic        rx_frame_valid_i,
  input  wire logic        rx_serial_bit0_i,
  input  wire logic [2:0]  rx_nibble_upper_i,
  input  wire logic        rx_symbol_error_i,
  output logic [7:0]       rx_byte_o,
  output logic             rx_byte_valid_o,
  output logic             rx_frame_end_o,
  output logic             rx_frame_err_o,
  input  wire logic        collision_in_i,
  input  wire logic        carrier_sense_in_i,
  output logic             collision_o,
  output logic             carrier_sense_o,
  input  wire logic        mgmt_start_i,
  input  wire logic        mgmt_read_i,
  input  wire logic [31:0] mgmt_frame_i,
  output logic             mgmt_busy_o,
  output logic             mgmt_done_o,
  output logic [15:0]      mgmt_rdata_o,
  output logic             mgmt_clock_out_o,
  input  wire logic        mgmt_data_line_i,
  output logic             mgmt_data_line_o,
  output logic             mgmt_data_line_oe_o
);

  generate
    if (MDC_HALF_CYC < 1 || MDC_HALF_CYC > 255)
    begin : g_bad_mdc
      $error("mpi_mac_pins MDC_HALF_CYC out of range 1..255");
    end
  endgenerate

  // ****************************************
  // helper functions
  // ****************************************
  // unit of a byte shown on the pins: bit in serial mode, nibble otherwise
  function automatic logic [3:0] tx_unit(input logic [7:0] b, input logic [2:0] idx,
                                         input logic ser);
    if (ser)
      tx_unit = {3'h0, b[idx]};
    else
      tx_unit = idx[0] ? b[7:4] : b[3:0];
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    rise = now && !prev;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // stage 1 is read only by stage 2; stage 3 only gives edge history
  logic [12:0] sy1_q;
  logic [12:0] sy2_q;
  logic [1:0]  clk3_q;
  wire  logic [12:0] pins = {tx_nibble_clock_i, rx_nibble_clock_i, rx_frame_valid_i,
                             rx_nibble_upper_i, rx_serial_bit0_i, rx_symbol_error_i,
                             collision_in_i, carrier_sense_in_i, mgmt_data_line_i,
                             pin_function_select_i, 1'b0};

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      sy1_q  <= '0;
      sy2_q  <= '0;
      clk3_q <= '0;
    end
    else
    begin
      sy1_q  <= pins;
      sy2_q  <= sy1_q;
      clk3_q <= sy2_q[12:11];
    end
  end

  wire logic       tx_rise = rise(sy2_q[12], clk3_q[1]);
  wire logic       rx_rise = rise(sy2_q[11], clk3_q[0]);
  wire logic       rx_dv   = sy2_q[10];
  wire logic [3:0] rx_nib  = sy2_q[9:6];
  wire logic       rx_er   = sy2_q[5];
  wire logic       mdio_in = sy2_q[2];
  wire logic       eth_en  = sy2_q[1];

  // ****************************************
  // transmit buffer and sequencer
  // ****************************************
  logic [9:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  mpi_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_tx_fifo
  (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .wr_data_i  ({tx_err_i, tx_last_i, tx_byte_i}),
    .wr_valid_i (tx_valid_i),
    .wr_ready_o (tx_ready_o),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop)
  );

  mpi_pkg::mpi_tx_state_t tx_state_q;
  logic [7:0]  tx_byte_q;
  logic [2:0]  tx_idx_q;
  logic        tx_last_q;
  logic        tx_err_q;

  // a byte is spent after two nibbles, or eight bits in serial mode
  wire logic [2:0] unit_max  = serial_mode_i ? `MPI_BIT_PER_BYTE : `MPI_NIB_PER_BYTE;
  wire logic       in_send   = (tx_state_q == mpi_pkg::MPI_TX_SEND);
  wire logic       byte_done = (tx_idx_q == unit_max);
  wire logic       want_byte = !in_send || (byte_done && !tx_last_q);
  assign fifo_pop = tx_rise && eth_en && want_byte;
  wire logic       take      = fifo_pop && fifo_valid;
  wire logic [2:0] idx_d     = take ? 3'h0 : tx_idx_q + 3'h1;
  wire logic [7:0] byte_d    = take ? fifo_data[7:0] : tx_byte_q;
  wire logic       err_d     = take ? fifo_data[9] : tx_err_q;
  wire logic       more      = in_send && !byte_done;
  wire logic       show      = take || more;
  wire logic [3:0] unit_d    = tx_unit(byte_d, idx_d, serial_mode_i);
  wire logic [3:0] pin_nib   = show ? unit_d : `MPI_TX_IDLE_NIB;

  // sequencer moves only on transmit clock edges
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !eth_en)
    begin
      tx_state_q <= mpi_pkg::MPI_TX_IDLE;
      tx_byte_q  <= '0;
      tx_idx_q   <= '0;
      tx_last_q  <= 1'b0;
      tx_err_q   <= 1'b0;
    end
    else if (tx_rise)
    begin
      tx_state_q <= show ? mpi_pkg::MPI_TX_SEND : mpi_pkg::MPI_TX_IDLE;
      tx_byte_q  <= byte_d;
      tx_idx_q   <= show ? idx_d : 3'h0;
      tx_last_q  <= take ? fifo_data[8] : tx_last_q;
      tx_err_q   <= err_d;
    end
  end

  // pin drivers change just after a transmit clock rise, stable by the next
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !eth_en)
    begin
      tx_frame_valid_o  <= 1'b0;
      tx_serial_bit0_o  <= 1'b0;
      tx_nibble_upper_o <= '0;
      tx_symbol_error_o <= 1'b0;
      tx_underrun_o     <= 1'b0;
    end
    else
    begin
      tx_underrun_o <= tx_rise && in_send && byte_done && !tx_last_q && !fifo_valid;
      if (tx_rise)
      begin
        tx_frame_valid_o  <= show;
        tx_serial_bit0_o  <= pin_nib[0];
        tx_nibble_upper_o <= pin_nib[3:1];
        tx_symbol_error_o <= show && err_d && !serial_mode_i;
      end
    end
  end

  // ****************************************
  // receive capture
  // ****************************************
  logic [2:0] rx_idx_q;
  logic       rx_dv_q;
  logic       rx_err_seen_q;
  wire  logic rx_cap  = rx_rise && rx_dv && eth_en;
  wire  logic rx_full = rx_idx_q == unit_max;
  wire  logic rx_bad  = rx_cap && rx_er && !serial_mode_i;
  wire  logic rx_end  = rx_rise && rx_dv_q && !rx_dv;
  // low nibble arrives first; serial bits shift in lsb first
  wire  logic [7:0] rx_asm = serial_mode_i ? {rx_nib[0], rx_byte_o[7:1]}
                                           : {rx_nib, rx_byte_o[7:4]};

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      rx_idx_q        <= '0;
      rx_dv_q         <= 1'b0;
      rx_err_seen_q   <= 1'b0;
      rx_byte_o       <= '0;
      rx_byte_valid_o <= 1'b0;
      rx_frame_end_o  <= 1'b0;
      rx_frame_err_o  <= 1'b0;
    end
    else
    begin
      rx_byte_valid_o <= rx_cap && rx_full;
      rx_frame_end_o  <= rx_end;
      rx_frame_err_o  <= rx_end && rx_err_seen_q;
      if (rx_rise)
      begin
        rx_dv_q <= rx_dv;
      end
      if (rx_cap)
      begin
        rx_byte_o <= rx_asm;
        rx_idx_q  <= rx_full ? 3'h0 : rx_idx_q + 3'h1;
      end
      else if (rx_rise)
      begin
        rx_idx_q <= 3'h0;
      end
      // a new error wins over the end-of-frame clear
      rx_err_seen_q <= rx_bad || (rx_err_seen_q && !rx_end);
    end
  end

  // line status, carrier meaningful only in nibble mode
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      collision_o     <= 1'b0;
      carrier_sense_o <= 1'b0;
    end
    else
    begin
      collision_o     <= sy2_q[4] && eth_en;
      carrier_sense_o <= sy2_q[3] && eth_en && !serial_mode_i;
    end
  end

  // ****************************************
  // management shifter
  // ****************************************
  mpi_pkg::mpi_mg_state_t mg_state_q;
  logic [63:0] mg_shift_q;
  logic [5:0]  mg_bit_q;
  logic [7:0]  mg_div_q;
  logic        mg_read_q;
  wire  logic  mg_busy = (mg_state_q == mpi_pkg::MPI_MG_SHIFT);
  wire  logic  mg_tick = mg_busy && (mg_div_q == 8'(MDC_HALF_CYC - 1));
  wire  logic  mg_fall = mg_tick && mgmt_clock_out_o;
  wire  logic  mg_rise = mg_tick && !mgmt_clock_out_o;
  wire  logic  mg_end  = mg_fall && (mg_bit_q == `MPI_MGMT_LAST_BIT);
  wire  logic  mg_go   = mgmt_start_i && !mg_busy && eth_en && !serial_mode_i;
  // read frames let go of the line from the turnaround onward
  wire  logic  mg_rel  = mg_read_q && ((mg_bit_q + 6'h1) >= `MPI_MGMT_TA_BIT);

  // state, clock divider and bit count
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !eth_en)                    // deselect aborts a transfer
    begin
      mg_state_q       <= mpi_pkg::MPI_MG_IDLE;
      mg_div_q         <= '0;
      mg_bit_q         <= '0;
      mg_read_q        <= 1'b0;
      mgmt_clock_out_o <= 1'b0;
      mgmt_done_o      <= 1'b0;
      mgmt_busy_o      <= 1'b0;
    end
    else
    begin
      mgmt_done_o <= mg_end;
      mgmt_busy_o <= mg_go || (mg_busy && !mg_end);
      if (mg_go)
      begin
        mg_state_q <= mpi_pkg::MPI_MG_SHIFT;
        mg_read_q  <= mgmt_read_i;
        mg_bit_q   <= '0;
        mg_div_q   <= '0;
      end
      else if (mg_busy)
      begin
        mg_div_q         <= mg_tick ? 8'h00 : mg_div_q + 8'h01;
        mgmt_clock_out_o <= mg_tick ? !mgmt_clock_out_o : mgmt_clock_out_o;
        mg_bit_q         <= mg_fall ? mg_bit_q + 6'h1 : mg_bit_q;
        mg_state_q       <= mg_end ? mpi_pkg::MPI_MG_IDLE : mg_state_q;
      end
    end
  end

  // data changes on the falling clock, sampled by the PHY on the rising one
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !eth_en)                    // line let go when deselected
    begin
      mg_shift_q          <= '0;
      mgmt_data_line_o    <= 1'b0;
      mgmt_data_line_oe_o <= 1'b0;
      mgmt_rdata_o        <= '0;
    end
    else if (mg_go)
    begin
      mg_shift_q          <= {`MPI_MGMT_PREAMBLE, mgmt_frame_i};
      mgmt_data_line_o    <= 1'b1;
      mgmt_data_line_oe_o <= 1'b1;
    end
    else if (mg_fall)
    begin
      mg_shift_q          <= {mg_shift_q[62:0], 1'b0};
      mgmt_data_line_o    <= mg_shift_q[62] && !mg_end;
      mgmt_data_line_oe_o <= !mg_end && !mg_rel;
    end
    else if (mg_rise && mg_read_q && mg_bit_q >= `MPI_MGMT_RD_BIT)
    begin
      mgmt_rdata_o <= {mgmt_rdata_o[14:0], mdio_in};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_mdc_high;
    mgmt_clock_out_o [*4];
  endsequence

  tx_pin_timing_a: assert property ($changed(tx_frame_valid_o) |-> $past(tx_rise) || $past(!eth_en))
    else $error("transmit valid moved off a transmit clock edge");
  tx_first_nib_a: assert property ($rose(tx_frame_valid_o) |-> $past(take))
    else $error("transmit valid rose without a byte taken");
  tx_frame_end_a: assert property (tx_rise && in_send && byte_done && tx_last_q |=> !tx_frame_valid_o)
    else $error("transmit valid held past final nibble");
  tx_idle_data_a: assert property (!tx_frame_valid_o |-> !tx_serial_bit0_o && tx_nibble_upper_o == 3'h0)
    else $error("transmit data active while not valid");
  tx_serial_bits_a: assert property (serial_mode_i && $stable(serial_mode_i) && tx_frame_valid_o |-> tx_nibble_upper_o == 3'h0)
    else $error("upper transmit bits used in serial mode");
  tx_err_gate_a: assert property (tx_symbol_error_o |-> tx_frame_valid_o && $past(err_d))
    else $error("transmit error outside a valid nibble");
  rx_err_gate_a: assert property ($rose(rx_err_seen_q) |-> $past(rx_dv) && $past(rx_rise))
    else $error("receive error taken while valid low");
  rx_capture_a: assert property (rx_byte_valid_o |-> $past(rx_dv) && $past(rx_rise))
    else $error("receive byte captured outside valid");
  mdc_half_a: assert property ($rose(mgmt_clock_out_o) |-> s_mdc_high)
    else $error("management clock high phase too short");
  mdio_drive_a: assert property (mgmt_data_line_oe_o |-> mg_busy)
    else $error("management data driven outside a transfer");
  pin_select_a: assert property (!eth_en |=> !tx_frame_valid_o && !mgmt_busy_o)
    else $error("ethernet pins active while deselected");

endmodule

/* include/mpi_consts.svh */
`ifndef MPI_CONSTS_SVH
`define MPI_CONSTS_SVH

// ****************************************
// clock and timing
// ****************************************
`define MPI_SYS_CLK_NS     40
`define MPI_MDC_HALF_NS    200
// least time, so round up to whole cycles
`define MPI_MDC_HALF_CYC   ((`MPI_MDC_HALF_NS + `MPI_SYS_CLK_NS - 1) / `MPI_SYS_CLK_NS)

// ****************************************
// management frame layout
// ****************************************
`define MPI_MGMT_BITS      64
`define MPI_MGMT_LAST_BIT  6'd63
`define MPI_MGMT_TA_BIT    6'd46
`define MPI_MGMT_RD_BIT    6'd48
`define MPI_MGMT_PREAMBLE  32'hffffffff

// ****************************************
// transmit path
// ****************************************
`define MPI_FIFO_DEPTH     4
`define MPI_NIB_PER_BYTE   3'd1
`define MPI_BIT_PER_BYTE   3'd7
`define MPI_TX_IDLE_NIB    4'h0

`endif

/* include/mpi_pkg.sv */
package mpi_pkg;

  // transmit sequencer, one-hot
  typedef enum logic [1:0]
  {
    MPI_TX_IDLE = 2'b01,
    MPI_TX_SEND = 2'b10
  } mpi_tx_state_t;

  // management shifter, one-hot
  typedef enum logic [1:0]
  {
    MPI_MG_IDLE  = 2'b01,
    MPI_MG_SHIFT = 2'b10
  } mpi_mg_state_t;

endpackage

/* logic/mpi_fifo.sv */
`timescale 1ns/1ns

module mpi_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer arithmetic wraps naturally only for powers of two
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("mpi_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;

  // ****************************************
  // flags and handshakes
  // ****************************************
  wire logic empty = (wptr_q == rptr_q);
  wire logic full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  wire logic push  = wr_valid_i && !full;
  wire logic pop   = rd_ready_i && !empty;

  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o  = mem_q[rptr_q[AW-1:0]];

  // storage has no reset; only pointers decide what is valid
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_q[wptr_q[AW-1:0]] <= wr_data_i;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      wptr_q <= wptr_q + (AW+1)'(push);
      rptr_q <= rptr_q + (AW+1)'(pop);
    end
  end

endmodule

/* test/mpi_phy_model.sv */
`timescale 1ns/1ns

// ****************************************
// transceiver model facing the mii pins
// ****************************************
module mpi_phy_model
(
  input  wire logic       serial_mode_i,
  input  wire logic       tx_frame_valid_i,
  input  wire logic       tx_serial_bit0_i,
  input  wire logic [2:0] tx_nibble_upper_i,
  input  wire logic       tx_symbol_error_i,
  output logic            tx_nibble_clock_o,
  output logic            rx_nibble_clock_o,
  output logic            rx_frame_valid_o,
  output logic            rx_serial_bit0_o,
  output logic [2:0]      rx_nibble_upper_o,
  output logic            rx_symbol_error_o,
  output logic            collision_o,
  output logic            carrier_sense_o,
  input  wire logic       mgmt_clock_i,
  input  wire logic       mgmt_oe_i,
  input  wire logic       mgmt_dout_i,
  output logic            mgmt_line_o
);
  logic [4:0]  tx_q [$];
  logic        tx_run;
  logic        phy_oe;
  logic        phy_bit;
  logic [15:0] rd_word;
  int          rise_n;
  logic [63:0] wr_bits;

  // transmit clock, phase unrelated to the system clock; still while idle
  initial
  begin
    {rx_nibble_clock_o, rx_frame_valid_o, rx_symbol_error_o} = 3'h0;
    {rx_nibble_upper_o, rx_serial_bit0_o} = 4'h0;
    {collision_o, carrier_sense_o, tx_run, phy_oe, phy_bit} = 5'h00;
    rd_word = 16'hb6c9;
    rise_n = 0;
    tx_nibble_clock_o = 1'b0;
    #13;
    forever
    begin
      #160;
      tx_nibble_clock_o = tx_run ? ~tx_nibble_clock_o : 1'b0;
    end
  end

  // take what the controller presents, only while it claims valid
  always @(posedge tx_nibble_clock_o)
    if (tx_frame_valid_i === 1'b1)
      tx_q.push_back({tx_symbol_error_i, tx_nibble_upper_i, tx_serial_bit0_i});

  task automatic set_lines(input logic col, input logic crs, input logic run);
    collision_o = col;
    carrier_sense_o = crs;
    tx_run = run;
  endtask

  // one frame then three idle units; the receive clock runs only while these last
  task automatic rx_frame(input logic [31:0] nib, input logic [7:0] err, input int n,
                          input logic err_idle);
    for (int i = 0; i < n; i++)
    begin
      rx_frame_valid_o = 1'b1;
      {rx_nibble_upper_o, rx_serial_bit0_o} = nib[4*i +: 4];
      rx_symbol_error_o = err[i];
      #160 rx_nibble_clock_o = 1'b1;
      #160 rx_nibble_clock_o = 1'b0;
    end
    for (int i = 0; i < 3; i++)
    begin
      rx_frame_valid_o = 1'b0;
      // stale data inverted so that a late capture cannot pass
      {rx_nibble_upper_o, rx_serial_bit0_o} = ~{rx_nibble_upper_o, rx_serial_bit0_o};
      rx_symbol_error_o = err_idle;
      #160 rx_nibble_clock_o = 1'b1;
      #160 rx_nibble_clock_o = 1'b0;
    end
    rx_symbol_error_o = 1'b0;
  endtask

  // turnaround zero then read word, each bit set up after a clock fall
  always @(posedge mgmt_oe_i) rise_n = 0;
  always @(posedge mgmt_clock_i) rise_n++;
  // bits the controller drives, taken on each rising clock
  always @(posedge mgmt_clock_i)
    if (mgmt_oe_i === 1'b1)
      wr_bits = {wr_bits[62:0], mgmt_dout_i};
  always @(negedge mgmt_clock_i)
  begin
    phy_oe = (mgmt_oe_i === 1'b0) && rise_n >= 47 && rise_n <= 63;
    phy_bit = (rise_n == 47) ? 1'b0 : rd_word[4'(63 - rise_n)];
  end

  // released line toggles; grounded in serial mode
  assign mgmt_line_o = serial_mode_i ? 1'b0 : mgmt_oe_i ? mgmt_dout_i :
                       phy_oe ? phy_bit : ~mgmt_clock_i;
endmodule

/* test/mpi_mac_pins_bench.sv */
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end

// ****************************************
// bench top
// ****************************************
module mpi_mac_pins_bench;
  logic        sys_clk, resetn, serial_mode, pin_sel;
  logic [7:0]  tx_byte;
  logic        tx_last, tx_err, tx_valid, tx_ready, tx_underrun;
  logic        tx_clk, tx_fv, tx_b0, tx_se, rx_clk, rx_fv, rx_b0, rx_se;
  logic [2:0]  tx_up, rx_up;
  logic [7:0]  rx_byte;
  logic        rx_bv, rx_end, rx_ferr, col_in, crs_in, col_o, crs_o;
  logic        mg_start, mg_read, mg_busy, mg_done, mdc, mdio, mdio_o, mdio_oe;
  logic [31:0] mg_frame;
  logic [15:0] mg_rdata;
  logic [7:0]  rx_seen [$];
  logic        ferr_seen [$];
  int          cycles, failures, check_count, underruns;

  mpi_mac_pins #(.FIFO_DEPTH(4), .MDC_HALF_CYC(5)) DUT (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .serial_mode_i(serial_mode),
    .pin_function_select_i(pin_sel), .tx_byte_i(tx_byte), .tx_last_i(tx_last),
    .tx_err_i(tx_err), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .tx_underrun_o(tx_underrun), .tx_nibble_clock_i(tx_clk), .tx_frame_valid_o(tx_fv),
    .tx_serial_bit0_o(tx_b0), .tx_nibble_upper_o(tx_up), .tx_symbol_error_o(tx_se),
    .rx_nibble_clock_i(rx_clk), .rx_frame_valid_i(rx_fv), .rx_serial_bit0_i(rx_b0),
    .rx_nibble_upper_i(rx_up), .rx_symbol_error_i(rx_se), .rx_byte_o(rx_byte),
    .rx_byte_valid_o(rx_bv), .rx_frame_end_o(rx_end), .rx_frame_err_o(rx_ferr),
    .collision_in_i(col_in), .carrier_sense_in_i(crs_in), .collision_o(col_o),
    .carrier_sense_o(crs_o), .mgmt_start_i(mg_start), .mgmt_read_i(mg_read),
    .mgmt_frame_i(mg_frame), .mgmt_busy_o(mg_busy), .mgmt_done_o(mg_done),
    .mgmt_rdata_o(mg_rdata), .mgmt_clock_out_o(mdc), .mgmt_data_line_i(mdio),
    .mgmt_data_line_o(mdio_o), .mgmt_data_line_oe_o(mdio_oe));

  mpi_phy_model phy (
    .serial_mode_i(serial_mode), .tx_frame_valid_i(tx_fv), .tx_serial_bit0_i(tx_b0),
    .tx_nibble_upper_i(tx_up), .tx_symbol_error_i(tx_se), .tx_nibble_clock_o(tx_clk),
    .rx_nibble_clock_o(rx_clk), .rx_frame_valid_o(rx_fv), .rx_serial_bit0_o(rx_b0),
    .rx_nibble_upper_o(rx_up), .rx_symbol_error_o(rx_se), .collision_o(col_in),
    .carrier_sense_o(crs_in), .mgmt_clock_i(mdc), .mgmt_oe_i(mdio_oe),
    .mgmt_dout_i(mdio_o), .mgmt_line_o(mdio));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // receive monitor and hang guard; far fewer cycles are needed
  always @(negedge sys_clk)
  begin
    if (tx_underrun === 1'b1) underruns++;
    if (rx_bv === 1'b1) rx_seen.push_back(rx_byte);
    if (rx_end === 1'b1) ferr_seen.push_back(rx_ferr);
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic push(input logic [7:0] b, input logic l, input logic e);
    @(negedge sys_clk);
    `CHK("tx_ready", 1'b1, tx_ready)
    {tx_byte, tx_last, tx_err} = {b, l, e};
    tx_valid = 1'b1;
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask

  // run the transmit clock until n units arrived and valid fell
  task automatic drain_tx(input int n);
    phy.set_lines(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 800 && !(phy.tx_q.size() == n && tx_fv === 1'b0); i++)
      @(negedge sys_clk);
    repeat (20) @(negedge sys_clk);
    phy.set_lines(1'b0, 1'b0, 1'b0);
    `CHK("tx_units", n, phy.tx_q.size())
  endtask

  task automatic tx_mii_case;
    logic [31:0] nib;
    logic [7:0]  erm;
    nib = 32'h3ca3d555;
    erm = 8'h30;
    push(8'h55, 1'b0, 1'b0);
    push(8'hd5, 1'b0, 1'b0);
    push(8'ha3, 1'b0, 1'b1);
    push(8'h3c, 1'b1, 1'b0);
    `CHK("tx_full", 1'b0, tx_ready)
    drain_tx(8);
    for (int i = 0; i < 8; i++)
      `CHK("tx_nibble", {erm[i], nib[4*i +: 4]}, phy.tx_q[i])
    `CHK("tx_no_underrun", 0, underruns)
    phy.tx_q.delete();
    // starved frame: cut after one byte, valid drops
    push(8'h77, 1'b0, 1'b0);
    drain_tx(2);
    `CHK("tx_underrun", 1, underruns)
    phy.tx_q.delete();
  endtask

  task automatic tx_serial_case;
    logic [7:0] b;
    b = 8'ha5;
    serial_mode = 1'b1;
    push(b, 1'b1, 1'b1);
    drain_tx(8);
    for (int i = 0; i < 8; i++)
      `CHK("tx_bit", {1'b0, b[i]}, {phy.tx_q[i][4], phy.tx_q[i][0]})
    phy.tx_q.delete();
    serial_mode = 1'b0;
  endtask

  task automatic rx_case;
    logic [7:0] exp_b [7];
    exp_b = '{8'h55, 8'h55, 8'hd5, 8'ha7, 8'h55, 8'h3c, 8'h96};
    phy.rx_frame(32'ha7d55555, 8'h40, 8, 1'b0);
    phy.rx_frame(32'h00003c55, 8'h00, 4, 1'b1);
    // serial frame: only bit 0 counts, upper bits and errors are noise
    serial_mode = 1'b1;
    phy.rx_frame(32'hfeefeffe, 8'hff, 8, 1'b0);
    serial_mode = 1'b0;
    repeat (10) @(negedge sys_clk);
    `CHK("rx_count", 7, rx_seen.size())
    for (int i = 0; i < 7; i++)
      `CHK("rx_byte", exp_b[i], rx_seen[i])
    `CHK("rx_ends", 3, ferr_seen.size())
    `CHK("rx_err_in", 1'b1, ferr_seen[0])
    `CHK("rx_err_idle", 1'b0, ferr_seen[1])
    `CHK("rx_err_ser", 1'b0, ferr_seen[2])
  endtask

  task automatic mgmt_pulse;
    @(negedge sys_clk);
    mg_start = 1'b1;
    @(negedge sys_clk);
    mg_start = 1'b0;
  endtask

  task automatic mgmt_case;
    `CHK("mdio_oe_rst", 1'b0, mdio_oe)
    serial_mode = 1'b1;
    mgmt_pulse();
    repeat (4) @(negedge sys_clk);
    `CHK("mg_busy_ser", 1'b0, mg_busy)
    `CHK("mdio_oe_ser", 1'b0, mdio_oe)
    serial_mode = 1'b0;
    mg_frame = {2'b01, 2'b10, 5'h01, 5'h02, 2'b11, 16'h0000};
    mg_read = 1'b1;
    mgmt_pulse();
    `CHK("mg_busy", 1'b1, mg_busy)
    for (int i = 0; i < 1000 && mg_done !== 1'b1; i++)
      @(negedge sys_clk);
    `CHK("mg_done", 1'b1, mg_done)
    `CHK("mg_busy_end", 1'b0, mg_busy)
    `CHK("mdio_wr", {32'hffffffff, mg_frame[31:18]}, phy.wr_bits[45:0])
    `CHK("mg_rdata", 16'hb6c9, mg_rdata)
    `CHK("mdc_rises", 64, phy.rise_n)
    `CHK("mdio_oe_end", 1'b0, mdio_oe)
  endtask

  task automatic lines_case;
    phy.set_lines(1'b1, 1'b1, 1'b0);
    repeat (5) @(negedge sys_clk);
    `CHK("collision", 1'b1, col_o)
    `CHK("carrier", 1'b1, crs_o)
    serial_mode = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("carrier_ser", 1'b0, crs_o)
    serial_mode = 1'b0;
    mgmt_pulse();
    pin_sel = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK("collision_off", 1'b0, col_o)
    `CHK("mg_busy_off", 1'b0, mg_busy)
    `CHK("mdio_oe_off", 1'b0, mdio_oe)
    `CHK("mdc_off", 1'b0, mdc)
    pin_sel = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK("collision_on", 1'b1, col_o)
    phy.set_lines(1'b0, 1'b0, 1'b0);
  endtask

  initial
  begin
    {resetn, serial_mode, tx_last, tx_err, tx_valid, mg_start, mg_read} = 7'h00;
    {tx_byte, mg_frame} = 40'h0;
    pin_sel = 1'b1;
    {cycles, failures, check_count} = {32'sd0, 32'sd0, 32'sd0};
    underruns = 0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    mgmt_case();
    tx_mii_case();
    tx_serial_case();
    rx_case();
    lines_case();
    complete_run();
  end
endmodule
